/* hw/spu_top.sv */
/*
  spu_top: security set password and unlock command handler, apb slave.
  assumes: apb master with 32-bit data; host writes one 256-word sector
  through the data register after issuing a data-out command.
*/
`timescale 1ns/1ps
module spu_top #(
  parameter bit SEC_SUPPORTED = 1'b1  // security feature set present
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  spu_pkg::spu_state_t state;      // command sequencer
  logic [7:0] opcode;              // command in progress
  logic [7:0] widx;                // sector word index
  logic [15:0] ctl_word;           // captured word 0
  logic [15:0] rev_in;             // captured word 17
  logic [255:0] pw_in;             // supplied password
  // stored security state lives in non-volatile storage: it takes its
  // power-on value once and a hardware reset must not wipe it
  logic [255:0] user_pw = '0;      // stored user password
  logic [255:0] master_pw = '0;    // stored master password
  logic user_set = 1'b0;           // user password armed for lock
  logic max_level = 1'b0;          // security level maximum
  logic locked;                    // lock mode active
  logic frozen;                    // frozen mode
  logic [2:0] tries;               // unlock attempt counter
  logic [15:0] rev_code = spu_pkg::REV_NONE;  // master revision code
  logic [7:0] status;              // command_status
  logic [7:0] errf;                // error_flags
  logic [7:0] drive_select;        // device register
  logic fault;                     // device fault input bit
  logic packet_set;                // packet feature set present
  logic wr_en;                     // apb write strobe
  logic cmd_wr;                    // command register write
  logic data_wr;                   // data register write
  logic next_abort;                // exec outcome abort
  logic pw_match;                  // compare result

  assign pready = 1'b1;  // zero wait states
  assign pslverr = 1'b0;
  assign wr_en = psel & penable & pwrite;
  assign cmd_wr = wr_en && paddr == spu_pkg::ADDR_CMD && state == spu_pkg::SPU_IDLE;
  assign data_wr = wr_en && paddr == spu_pkg::ADDR_DATA && state == spu_pkg::SPU_XFER;

  // ----------------------------------------------------------------
  // outcome of the captured command
  // ----------------------------------------------------------------
  // compare against master or user password by selector
  always_comb begin
    pw_match = 1'b0;
    if (ctl_word[spu_pkg::CW_ID]) begin
      pw_match = !max_level && pw_in == master_pw;
    end else begin
      pw_match = pw_in == user_pw;
    end
  end

  // decide abort for the executing command
  always_comb begin
    next_abort = 1'b0;
    if (opcode == spu_pkg::OP_SET_PW) begin
      next_abort = !SEC_SUPPORTED || locked || frozen;
    end else if (opcode == spu_pkg::OP_UNLOCK) begin
      // counter exhausted or mismatch while locked aborts
      next_abort = !SEC_SUPPORTED || frozen || tries == 3'h0 ||
        (locked && !pw_match);
    end else if (opcode == spu_pkg::OP_SEEK) begin
      next_abort = packet_set;
    end else begin
      next_abort = 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // idle -> transfer for data-out commands, exec for non-data
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      state <= spu_pkg::SPU_IDLE;
      opcode <= 8'h00;
      widx <= 8'h00;
    end else begin
      unique case (state)
        spu_pkg::SPU_IDLE: begin
          if (cmd_wr) begin
            opcode <= pwdata[7:0];
            widx <= 8'h00;
            // data-out commands take one sector first
            if (pwdata[7:0] == spu_pkg::OP_SET_PW ||
                pwdata[7:0] == spu_pkg::OP_UNLOCK) begin
              state <= spu_pkg::SPU_XFER;
            end else begin
              state <= spu_pkg::SPU_EXEC;
            end
          end
        end
        spu_pkg::SPU_XFER: begin
          if (data_wr) begin
            widx <= widx + 8'h01;
            if (widx == spu_pkg::SECT_LAST) begin
              state <= spu_pkg::SPU_EXEC;
            end
          end
        end
        spu_pkg::SPU_EXEC: begin
          state <= spu_pkg::SPU_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // sector capture
  // ----------------------------------------------------------------
  // control word, password words and revision word
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ctl_word <= 16'h0000;
      rev_in <= 16'h0000;
      pw_in <= '0;
    end else if (data_wr) begin
      if (widx == 8'h00) begin
        ctl_word <= pwdata[15:0];
      end
      if (widx >= spu_pkg::PW_FIRST && widx <= spu_pkg::PW_LAST) begin
        pw_in[(widx - spu_pkg::PW_FIRST) * 16 +: 16] <= pwdata[15:0];
      end
      if (widx == spu_pkg::REV_WORD) begin
        rev_in <= pwdata[15:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // security state
  // ----------------------------------------------------------------
  // passwords, level, revision code; kept through reset so that an armed
  // user password still locks the device after the next reset
  always_ff @(posedge clk_sys) begin
    if (rstn && state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_SET_PW && !next_abort) begin
      if (ctl_word[spu_pkg::CW_ID]) begin
        master_pw <= pw_in;
        rev_code <= rev_in;
      end else begin
        user_pw <= pw_in;
        max_level <= ctl_word[spu_pkg::CW_LVL];
        user_set <= 1'b1;
      end
    end
  end

  // lock takes effect at the reset after a user password is armed;
  // synchronous reset samples the armed flag so it survives the reset
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      locked <= user_set;
    end else if (state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_UNLOCK && !next_abort) begin
      locked <= 1'b0;
    end
  end

  // attempt counter, only mismatches while locked count
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      tries <= spu_pkg::TRIES_INIT;
    end else if (state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_UNLOCK &&
                 locked && !frozen && !pw_match && tries != 3'h0) begin
      tries <= tries - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  // control bits and drive select; freeze is sticky until reset
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      frozen <= 1'b0;
      fault <= 1'b0;
      packet_set <= 1'b0;
      drive_select <= 8'h00;
    end else if (wr_en && state == spu_pkg::SPU_IDLE) begin
      if (paddr == spu_pkg::ADDR_CTRL) begin
        frozen <= frozen | pwdata[spu_pkg::CTL_FRZ];
        fault <= pwdata[spu_pkg::CTL_FLT];
        packet_set <= pwdata[spu_pkg::CTL_PKT];
      end
      if (paddr == spu_pkg::ADDR_DRIVE) begin
        drive_select <= pwdata[7:0];
      end
    end
  end

  // status and error registers
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      status <= spu_pkg::STATUS_IDLE;
      errf <= 8'h00;
    end else if (cmd_wr) begin
      status <= 8'h00;
      status[spu_pkg::ST_BSY] <= 1'b1;
      status[spu_pkg::ST_DRDY] <= 1'b1;
      errf <= 8'h00;
    end else if (state == spu_pkg::SPU_XFER) begin
      status[spu_pkg::ST_BSY] <= 1'b0;
      status[spu_pkg::ST_DRQ] <= 1'b1;
      if (data_wr && widx == spu_pkg::SECT_LAST) begin
        status[spu_pkg::ST_BSY] <= 1'b1;
        status[spu_pkg::ST_DRQ] <= 1'b0;
      end
    end else if (state == spu_pkg::SPU_EXEC) begin
      status <= 8'h00;
      status[spu_pkg::ST_DRDY] <= 1'b1;
      status[spu_pkg::ST_DF] <= next_abort & fault;
      status[spu_pkg::ST_ERR] <= next_abort;
      errf <= 8'h00;
      errf[spu_pkg::ER_ABRT] <= next_abort;
    end
  end

  // read mux, unmapped reads zero
  always_comb begin
    prdata = 32'h0000_0000;
    unique case (paddr)
      spu_pkg::ADDR_CMD: prdata = {24'h000000, opcode};
      spu_pkg::ADDR_STATUS: prdata = {24'h000000, status};
      spu_pkg::ADDR_ERROR: prdata = {24'h000000, errf};
      spu_pkg::ADDR_DRIVE: prdata = {24'h000000, drive_select};
      spu_pkg::ADDR_SEC: prdata = {25'h0000000, tries, user_set, max_level, frozen, locked};
      spu_pkg::ADDR_REV: prdata = {16'h0000, rev_code};
      spu_pkg::ADDR_CTRL: prdata = {29'h00000000, packet_set, fault, frozen};
      default: prdata = 32'h0000_0000;
    endcase
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_set_locked_abort: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_SET_PW && locked
    |=> errf[spu_pkg::ER_ABRT] && status[spu_pkg::ST_ERR]) else $error("set pw not aborted");
  a_done_ok_status: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && !next_abort |=> status == spu_pkg::STATUS_IDLE)
    else $error("bad success status");
  a_err_tracks: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_IDLE |-> status[spu_pkg::ST_ERR] == (errf != 8'h00))
    else $error("err bit mismatch");
  a_unlock_frozen: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_UNLOCK && frozen
    |=> errf[spu_pkg::ER_ABRT] && $stable(tries)) else $error("frozen unlock");
  a_tries_dec: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_UNLOCK && locked && !frozen
    && !pw_match && tries != 3'h0 |=> tries == $past(tries) - 3'h1) else $error("no dec");
  a_unlocked_tries: assert property (@(posedge clk_sys) disable iff (!rstn)
    !locked |=> tries == $past(tries)) else $error("counter moved");
  a_frozen_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    frozen |=> frozen) else $error("frozen cleared");
  a_master_keeps: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_SET_PW && ctl_word[spu_pkg::CW_ID]
    |=> $stable(max_level) && $stable(locked)) else $error("master changed lock");
  a_sector_len: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_XFER ##1 state == spu_pkg::SPU_EXEC |-> $past(widx) == 8'hFF)
    else $error("short sector");
  // ----------------------------------------------------------------
  // stored state and completion checks
  // ----------------------------------------------------------------
  // a master set copies the revision word
  a_rev_loaded: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_SET_PW && ctl_word[spu_pkg::CW_ID]
    && !next_abort |=> rev_code == $past(rev_in)) else $error("revision not loaded");
  // a user set leaves the revision code alone
  a_user_rev_kept: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_SET_PW && !ctl_word[spu_pkg::CW_ID]
    |=> $stable(rev_code)) else $error("revision changed by user set");
  // a user set stores the password and arms the lock
  a_user_store: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_SET_PW && !ctl_word[spu_pkg::CW_ID]
    && !next_abort |=> user_set && user_pw == $past(pw_in)) else $error("user pw not kept");
  // a user set takes the level from the control word
  a_user_level: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_SET_PW && !ctl_word[spu_pkg::CW_ID]
    && !next_abort |=> max_level == $past(ctl_word[spu_pkg::CW_LVL])) else $error("bad level");
  // frozen blocks set password
  a_set_frozen: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_SET_PW && frozen
    |=> errf[spu_pkg::ER_ABRT]) else $error("frozen set pw");
  // master unlock at maximum level is refused while locked
  a_max_master_rej: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_UNLOCK && locked
    && ctl_word[spu_pkg::CW_ID] && max_level |=> errf[spu_pkg::ER_ABRT] && locked)
    else $error("master unlocked max level");
  // an accepted unlock clears the lock with clean status
  a_unlock_clears: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_UNLOCK && !next_abort
    |=> !locked && status == spu_pkg::STATUS_IDLE) else $error("unlock left lock");
  // an exhausted counter refuses every unlock and stays at zero
  a_tries_spent: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_UNLOCK && tries == 3'h0
    |=> errf[spu_pkg::ER_ABRT] && tries == 3'h0) else $error("spent counter unlocked");
  // seek is refused where the packet set is present
  a_seek_packet: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_SEEK && packet_set
    |=> errf[spu_pkg::ER_ABRT]) else $error("seek with packet set");
  // a taken command shows busy with ready
  a_busy_cmd: assert property (@(posedge clk_sys) disable iff (!rstn)
    cmd_wr |=> status[spu_pkg::ST_BSY] && status[spu_pkg::ST_DRDY])
    else $error("command not busy");
  // idle never shows busy
  a_idle_free: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_IDLE |-> !status[spu_pkg::ST_BSY]) else $error("busy in idle");
  // the sector phase asks for data without busy
  a_xfer_drq: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_XFER && $past(state) == spu_pkg::SPU_XFER
    |-> status[spu_pkg::ST_DRQ] && !status[spu_pkg::ST_BSY]) else $error("no data request");
  // execution never leaves a data request standing
  a_exec_no_drq: assert property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC |-> !status[spu_pkg::ST_DRQ]) else $error("drq in exec");
  // main scenarios
  c_master_set: cover property (@(posedge clk_sys) disable iff (!rstn)
    state == spu_pkg::SPU_EXEC && opcode == spu_pkg::OP_SET_PW && ctl_word[spu_pkg::CW_ID]);
  c_unlock_ok: cover property (@(posedge clk_sys) disable iff (!rstn)
    $fell(locked));
  c_set_user: cover property (@(posedge clk_sys) disable iff (!rstn)
    $rose(user_set));
  c_tries_zero: cover property (@(posedge clk_sys) disable iff (!rstn)
    tries == 3'h0);
endmodule

/* hw/spu_pkg.sv */
/*
  spu_pkg: constants for the security password unlock block.
  assumes: apb register map with 32-bit words, 16-bit sector data words.
*/
package spu_pkg;
  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CMD = 8'h00;    // command opcode, write starts command
  localparam logic [7:0] ADDR_DATA = 8'h04;   // sector data word in
  localparam logic [7:0] ADDR_STATUS = 8'h08; // command_status
  localparam logic [7:0] ADDR_ERROR = 8'h0C;  // error_flags
  localparam logic [7:0] ADDR_DRIVE = 8'h10;  // drive_select
  localparam logic [7:0] ADDR_SEC = 8'h14;    // security state view
  localparam logic [7:0] ADDR_REV = 8'h18;    // identify word 92 view
  localparam logic [7:0] ADDR_CTRL = 8'h1C;   // freeze, fault, packet set
  // ----------------------------------------------------------------
  // opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_SET_PW = 8'hF1;
  localparam logic [7:0] OP_UNLOCK = 8'hF2;
  localparam logic [7:0] OP_SEEK = 8'h70;
  // ----------------------------------------------------------------
  // fields
  // ----------------------------------------------------------------
  localparam int ST_BSY = 7;
  localparam int ST_DRDY = 6;
  localparam int ST_DF = 5;
  localparam int ST_DRQ = 3;
  localparam int ST_ERR = 0;
  localparam int ER_ABRT = 2;
  localparam int CW_ID = 0;    // control word selector bit
  localparam int CW_LVL = 8;   // control word level bit
  localparam int CTL_FRZ = 0;
  localparam int CTL_FLT = 1;
  localparam int CTL_PKT = 2;
  localparam logic [7:0] PW_FIRST = 8'h01;   // first password word
  localparam logic [7:0] PW_LAST = 8'h10;    // last password word
  localparam logic [7:0] REV_WORD = 8'h11;   // revision code word
  localparam logic [7:0] SECT_LAST = 8'hFF;  // last word of sector
  localparam logic [2:0] TRIES_INIT = 3'h5;
  localparam logic [15:0] REV_NONE = 16'h0000;
  localparam logic [7:0] STATUS_IDLE = 8'h40;
  // ----------------------------------------------------------------
  // states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    SPU_IDLE = 3'b001,
    SPU_XFER = 3'b010,
    SPU_EXEC = 3'b100
  } spu_state_t;
endpackage

/* testbench/spu_host.sv */
/*
  spu_host: host adapter model, apb master issuing commands and one-sector pio data.
  assumes: shares clk_sys with the device; pready may hold off the access phase.
*/
`timescale 1ns/1ps
module spu_host (
  input wire logic clk_sys,
  input wire logic pready,
  input wire logic [31:0] prdata,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata
);
  int tmo = 0; // waits that ran out, plus commands that found the device not ready
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  // -----------------------------------------------------------------
  // one apb transfer: setup, then access held until pready
  // -----------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    int n;
    n = 0;
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (!pready && n < 50);
    if (n >= 50) tmo++;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // sector word: control, password words, revision code, then zero
  function automatic logic [15:0] word(int i, logic [15:0] cw, logic [7:0] sd,
                                       logic [15:0] rev);
    if (i == 0) return cw;
    if (i <= 16) return {sd, 8'(i)};
    if (i == 17) return rev;
    return 16'h0;
  endfunction
  // poll status while busy; a data request ends it when dq is set
  task automatic poll(input logic dq, output logic [31:0] r);
    int n;
    n = 0;
    do begin
      xfer(1'b0, spu_pkg::ADDR_STATUS, 32'h0, r);
      n++;
    end while (r[spu_pkg::ST_BSY] && !(dq && r[spu_pkg::ST_DRQ]) && n < 20);
    if (n >= 20) tmo++;
  endtask
  // -----------------------------------------------------------------
  // full command: wait ready, opcode, sector if asked, final status
  // -----------------------------------------------------------------
  task automatic issue(input logic [7:0] op, input logic [15:0] cw, input logic [7:0] sd,
                       input logic [15:0] rev, output logic [7:0] st, output logic [7:0] er);
    logic [31:0] r;
    poll(1'b0, r);
    if (!r[spu_pkg::ST_DRDY]) tmo++;
    xfer(1'b1, spu_pkg::ADDR_CMD, {24'h0, op}, r);
    poll(1'b1, r);
    // exactly one sector of 256 words
    if (r[spu_pkg::ST_DRQ]) begin
      for (int i = 0; i < 256; i++) begin
        xfer(1'b1, spu_pkg::ADDR_DATA, {16'h0, word(i, cw, sd, rev)}, r);
      end
    end
    poll(1'b0, r);
    st = r[7:0];
    xfer(1'b0, spu_pkg::ADDR_ERROR, 32'h0, r);
    er = r[7:0];
  endtask
endmodule

/* testbench/testbench.sv */
/*
  testbench: runs spu_top through the host model and checks status and error
  after each command, and security state and revision code between commands.
  assumes: spu_host beside it; every register reached over apb.
*/
`timescale 1ns/1ps
module testbench;
  logic clk_sys, rstn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  int err_total = 0;
  int n_checks = 0;
  localparam logic [7:0] OK = 8'h40, AB = 8'h41, AX = 8'h04;
  localparam logic [7:0] SEC = spu_pkg::ADDR_SEC, REV = spu_pkg::ADDR_REV;
  localparam logic [7:0] CTL = spu_pkg::ADDR_CTRL;
  spu_top dut (.clk_sys(clk_sys), .rstn(rstn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));
  spu_host host (.clk_sys(clk_sys), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  // -----------------------------------------------------------------
  // helpers
  // -----------------------------------------------------------------
  task automatic conclude();
    err_total += host.tmo;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
    if (host.tmo > 0) conclude();
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    host.xfer(1'b1, a, d, r);
  endtask
  task automatic reg_is(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    host.xfer(1'b0, a, 32'h0, r);
    chk(r, e, "register");
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] cw, input logic [7:0] sd,
                     input logic [15:0] rev, input logic [7:0] es, input logic [7:0] ee);
    logic [7:0] st, er;
    host.issue(op, cw, sd, rev, st, er);
    chk({24'h0, st}, {24'h0, es}, "status");
    chk({24'h0, er}, {24'h0, ee}, "error");
  endtask
  task automatic rst(input int n);
    rstn <= 1'b0;
    repeat (n) @(posedge clk_sys);
    rstn <= 1'b1;
  endtask
  // -----------------------------------------------------------------
  // scenarios
  // -----------------------------------------------------------------
  task automatic t_master();
    reg_is(spu_pkg::ADDR_STATUS, 32'h40);
    reg_is(SEC, 32'h50);
    reg_is(REV, 32'h0);
    cmd(8'hF1, 16'h0001, 8'hA5, 16'h1234, OK, 8'h00);
    reg_is(REV, 32'h1234);
    cmd(8'hF1, 16'h0101, 8'hA5, 16'hFFFE, OK, 8'h00);
    reg_is(REV, 32'hFFFE);
    reg_is(SEC, 32'h50);
    $display("test master done");
  endtask
  task automatic t_user_high();
    cmd(8'hF1, 16'h0000, 8'h3C, 16'h0BAD, OK, 8'h00);
    reg_is(REV, 32'hFFFE);
    reg_is(SEC, 32'h58);
    rst(2);
    reg_is(SEC, 32'h59);
    cmd(8'hF1, 16'h0001, 8'hA5, 16'h1111, AB, AX);
    reg_is(REV, 32'hFFFE);
    cmd(8'hF2, 16'h0000, 8'h77, 16'h0, AB, AX);
    reg_is(SEC, 32'h49);
    cmd(8'hF2, 16'h0001, 8'hA5, 16'h0, OK, 8'h00);
    reg_is(SEC, 32'h48);
    cmd(8'hF2, 16'h0000, 8'h77, 16'h0, OK, 8'h00);
    reg_is(SEC, 32'h48);
    $display("test user high done");
  endtask
  task automatic t_user_max();
    cmd(8'hF1, 16'h0100, 8'h3C, 16'h0, OK, 8'h00);
    rst(2);
    reg_is(SEC, 32'h5D);
    cmd(8'hF2, 16'h0001, 8'hA5, 16'h0, AB, AX);
    reg_is(SEC, 32'h4D);
    for (int i = 3; i >= 0; i--) begin
      cmd(8'hF2, 16'h0000, 8'h77, 16'h0, AB, AX);
      reg_is(SEC, {25'h0, 3'(i), 4'hD});
    end
    cmd(8'hF2, 16'h0000, 8'h3C, 16'h0, AB, AX);
    rst(2);
    reg_is(SEC, 32'h5D);
    cmd(8'hF2, 16'h0000, 8'h3C, 16'h0, OK, 8'h00);
    $display("test user max done");
  endtask
  task automatic t_freeze();
    wr(CTL, 32'h1);
    reg_is(SEC, 32'h5E);
    cmd(8'hF1, 16'h0000, 8'h3C, 16'h0, AB, AX);
    cmd(8'hF2, 16'h0000, 8'h3C, 16'h0, AB, AX);
    wr(CTL, 32'h0);
    reg_is(SEC, 32'h5E);
    rst(2);
    reg_is(SEC, 32'h5D);
    $display("test freeze done");
  endtask
  task automatic t_seek();
    cmd(8'h70, 16'h0, 8'h0, 16'h0, OK, 8'h00);
    wr(CTL, 32'h2);
    cmd(8'h70, 16'h0, 8'h0, 16'h0, OK, 8'h00);
    wr(CTL, 32'h4);
    cmd(8'h70, 16'h0, 8'h0, 16'h0, AB, AX);
    wr(CTL, 32'h6);
    cmd(8'h70, 16'h0, 8'h0, 16'h0, 8'h61, AX);
    cmd(8'h00, 16'h0, 8'h0, 16'h0, 8'h61, AX);
    // read-only, read-write and unmapped places
    wr(spu_pkg::ADDR_STATUS, 32'h0);
    reg_is(spu_pkg::ADDR_STATUS, 32'h61);
    wr(spu_pkg::ADDR_ERROR, 32'h0);
    reg_is(spu_pkg::ADDR_ERROR, 32'h4);
    wr(spu_pkg::ADDR_DRIVE, 32'hA0);
    reg_is(spu_pkg::ADDR_DRIVE, 32'hA0);
    wr(8'h20, 32'hFFFF);
    reg_is(8'h20, 32'h0);
    $display("test seek done");
  endtask
  initial begin
    rstn = 1'b0;
    rst(20);
    t_master();
    t_user_high();
    t_user_max();
    t_freeze();
    t_seek();
    conclude();
  end
endmodule
